// ==== bench/spr_chk.sv ====
module spr_chk
  import spr_pkg::*;
#(
  parameter int unsigned WORD_W = REG_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic load_i,
  input wire logic [WORD_W-1:0] reg_file_o [REG_COUNT],
  input wire spr_status_t status_o,
  input wire logic [7:0] oscillator_mult_o,
  input wire logic write_pulse_o
);
  logic [6:0] ratio;
  logic [10:0] modv;
  logic [10:0] fracv;
  assign ratio = reg_file_o[0][9:3];
  assign modv = reg_file_o[1][13:3];
  assign fracv = reg_file_o[2][13:3];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_reset_val: assert property ($rose(rst_n_i) |-> reg_file_o[0] == 24'h0001c0)
    else $error("integer divide reset value wrong");
  a_pulse_one: assert property (write_pulse_o |=> !write_pulse_o)
    else $error("write pulse longer than one cycle");
  a_reg_cause: assert property (!$stable(reg_file_o[0]) |-> ##[0:1] write_pulse_o)
    else $error("register changed without write pulse");
  a_mode_dec: assert property (status_o.mode == spr_div_mode_t'(reg_file_o[0][10]))
    else $error("divide mode decode wrong");
  a_ratio_dec: assert property (status_o.int_ratio == ratio)
    else $error("ratio decode wrong");
  a_int_range: assert property (status_o.mode == SPR_MODE_INTEGER |->
    status_o.settings_valid == (ratio >= 7'h15 && ratio <= 7'h7b)) else $error("integer range");
  a_frac_range: assert property (!status_o.mode && modv != 11'h000 && fracv < modv |->
    status_o.settings_valid == (ratio >= 7'h18 && ratio <= 7'h77)) else $error("frac range");
  a_mult_val: assert property ($stable(reg_file_o[0]) [*3] |->
    oscillator_mult_o == (reg_file_o[0][10] ? {ratio, 1'b0} : 8'h00)) else $error("mult wrong");
  a_init_mask: assert property (status_o.init_done |-> status_o.written_mask == 8'hff)
    else $error("init done before all written");
  a_freeze_hold: assert property (!clk_en_i |=> $stable(reg_file_o[0]))
    else $error("register moved while frozen");
endmodule // spr_chk

bind spr_config_regs spr_chk #(.WORD_W(WORD_W)) u_chk (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .sclk_i(sclk_i), .sdata_i(sdata_i),
  .load_i(load_i), .reg_file_o(reg_file_o), .status_o(status_o),
  .oscillator_mult_o(oscillator_mult_o), .write_pulse_o(write_pulse_o));

// ==== bench/spr_config_regs_test.sv ====
module spr_config_regs_test
  import spr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic clk_en_i = 1'b1;
  wire logic sclk;
  wire logic sdata;
  wire logic load;
  logic [23:0] regs [REG_COUNT];
  spr_status_t st;
  logic [7:0] mult;
  logic wp;
  int mdl[8];
  int n_fail = 0;
  int tests_run = 0;
  int tbl[8] = '{20, 21, 123, 124, 23, 119, 120, 24};
  spr_host_model host (.sclk_o(sclk), .sdata_o(sdata), .load_o(load));
  spr_config_regs DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .sclk_i(sclk), .sdata_i(sdata), .load_i(load), .reg_file_o(regs), .status_o(st),
    .oscillator_mult_o(mult), .write_pulse_o(wp));
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(string name, logic [23:0] seen, logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic do_reset;
    rst_n_i = 1'b0;
    repeat (16) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    mdl = '{RST_INTEGER_DIVIDE_CONTROL, RST_MODULUS_DIVIDE, RST_FRACTIONAL_DIVIDE, 0, 0, 0, 0, 0};
    @(negedge ref_clk_i);
  endtask
  task automatic cmp_all;
    int r, m, f, md;
    bit ok;
    for (int i = 0; i < 8; i++) chk("register", regs[i], 24'(mdl[i]));
    r = (mdl[0] >> 3) & 127;
    m = (mdl[1] >> 3) & 2047;
    f = (mdl[2] >> 3) & 2047;
    md = (mdl[0] >> 10) & 1;
    ok = md ? (r >= INT_MIN_INTEGER && r <= INT_MAX_INTEGER) :
      (r >= INT_MIN_FRACTIONAL && r <= INT_MAX_FRACTIONAL && m >= 1 && f < m);
    chk("valid", 24'(st.settings_valid), 24'(ok));
    chk("mult", 24'(mult), md ? 24'(2 * r) : 24'h000000);
    chk("mode", 24'(st.mode), 24'(md));
  endtask
  task automatic wr(logic [23:0] w);
    int n;
    n = 0;
    host.send(w, $urandom % 8);
    while (wp !== 1'b1 && n < 20) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("pulse", 24'(wp), 24'h000001);
    mdl[w[2:0]] = w;
    repeat (3) @(negedge ref_clk_i);
    cmp_all();
  endtask
  initial begin
    void'($urandom(26720));
    do_reset();
    cmp_all();
    $display("test reset done");
    for (int i = 7; i >= 0; i--) wr({21'($urandom), 3'(i)});
    chk("init", 24'(st.init_done), 24'h000001);
    $display("test first order done");
    repeat (12) wr({21'($urandom), 3'($urandom)});
    $display("test random updates done");
    wr({10'h000, 11'h064, 3'h1});
    wr({10'h000, 11'h032, 3'h2});
    for (int i = 0; i < 8; i++) wr({13'h0000, i < 4, 7'(tbl[i]), 3'h0});
    wr({10'h000, 11'h064, 3'h2});
    wr({10'h000, 11'h063, 3'h2});
    $display("test ratio limits done");
    clk_en_i = 1'b0;
    host.send(24'h00abc5, 0);
    repeat (4) @(negedge ref_clk_i);
    clk_en_i = 1'b1;
    repeat (8) begin
      @(negedge ref_clk_i);
      chk("pulse held", 24'(wp), 24'h000000);
    end
    cmp_all();
    $display("test clock enable done");
    do_reset();
    cmp_all();
    $display("test second reset done");
    wr({21'($urandom), 3'h0});
    $display("test write after reset done");
    report_and_stop();
  end
  initial begin
    #200us;
    n_fail++;
    report_and_stop();
  end
endmodule // spr_config_regs_test

// ==== bench/spr_host_model.sv ====
module spr_host_model (
  output logic sclk_o,
  output logic sdata_o,
  output logic load_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    load_o = 1'b0;
  end
  // Word out MSB first, clock idle low between frames
  task automatic send(input logic [23:0] w, input int slow);
    for (int i = 23; i >= 0; i--) begin
      sdata_o = w[i];
      #(6 + slow) sclk_o = 1'b1;
      #6 sclk_o = 1'b0;
    end
    sdata_o = ~w[0];
    load_o = 1'b1;
    #6 sclk_o = 1'b1;
    #6 sclk_o = 1'b0;
    load_o = 1'b0;
  endtask
endmodule // spr_host_model

// ==== include/spr_pkg.sv ====
package spr_pkg;
  localparam int unsigned REG_W = 24;
  localparam int unsigned REG_COUNT = 8;
  localparam int unsigned SEL_W = 3;
  // Register indices
  localparam logic [2:0] IDX_INTEGER_DIVIDE_CONTROL = 3'h0;
  localparam logic [2:0] IDX_MODULUS_DIVIDE = 3'h1;
  localparam logic [2:0] IDX_FRACTIONAL_DIVIDE = 3'h2;
  localparam logic [2:0] IDX_DITHER = 3'h3;
  localparam logic [2:0] IDX_CHARGE_PUMP = 3'h4;
  localparam logic [2:0] IDX_LO_PATH = 3'h5;
  localparam logic [2:0] IDX_OSC_CONTROL = 3'h6;
  localparam logic [2:0] IDX_EXT_OSC = 3'h7;
  // Reset values
  localparam logic [23:0] RST_INTEGER_DIVIDE_CONTROL = 24'h0001c0;
  localparam logic [23:0] RST_MODULUS_DIVIDE = 24'h003001;
  localparam logic [23:0] RST_FRACTIONAL_DIVIDE = 24'h001802;
  localparam logic [23:0] RST_OTHER = 24'h000000;
  // Field positions
  localparam int unsigned DIVIDE_MODE_BIT = 10;
  localparam int unsigned INT_RATIO_LSB = 3;
  localparam int unsigned INT_RATIO_W = 7;
  localparam int unsigned MODULUS_LSB = 3;
  localparam int unsigned MODULUS_W = 11;
  localparam int unsigned FRAC_LSB = 3;
  localparam int unsigned FRAC_W = 11;
  // Ratio limits
  localparam logic [6:0] INT_MIN_INTEGER = 7'h15;
  localparam logic [6:0] INT_MAX_INTEGER = 7'h7b;
  localparam logic [6:0] INT_MIN_FRACTIONAL = 7'h18;
  localparam logic [6:0] INT_MAX_FRACTIONAL = 7'h77;
  localparam logic [10:0] MODULUS_MIN = 11'h001;
  localparam logic [10:0] MODULUS_MAX = 11'h7ff;
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic {SPR_MODE_FRACTIONAL, SPR_MODE_INTEGER} spr_div_mode_t;

  typedef struct packed {
    logic [2:0] sel;
    logic [23:0] data;
  } spr_write_t;

  typedef struct packed {
    spr_div_mode_t mode;
    logic [6:0] int_ratio;
    logic [10:0] fractional_modulus;
    logic [10:0] frac_value;
    logic settings_valid;
    logic [7:0] written_mask;
    logic init_done;
  } spr_status_t;
endpackage

// ==== logic/spr_config_regs.sv ====
// What this block does
// - All configuration arrives over the three-wire serial port only.
// - Eight configuration registers, each 24 bits wide.
// - After all eight written, any single register may be rewritten.
// - Low three word bits pick the register; 000 is integer divide.
// - Integer divide control resets to 0x0001c0.
// - Divide-mode bit picks fractional or integer divider mode.
// - Integer mode ratio spans 21 to 123.
// - Integer mode: oscillator frequency is twice detector rate times ratio.
// - Registers 0 to 7 hold divider, dither, pump, LO, oscillator settings.
// - Code 001 selects modulus, 010 selects fractional value.
// - Fractional mode ratio spans 24 to 119.
// - Modulus spans 1 to 2047; fractional value below modulus.
module spr_config_regs
  import spr_pkg::*;
#(
  parameter int unsigned WORD_W = REG_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic load_i,
  output logic [WORD_W-1:0] reg_file_o [REG_COUNT],
  output spr_status_t status_o,
  output logic [7:0] oscillator_mult_o,
  output logic write_pulse_o
);
  // ****************************************
  // Serial link domain
  // ****************************************
  logic [WORD_W-1:0] link_word;
  logic link_toggle;

  spr_shifter #(.WORD_W(WORD_W)) u_shifter (
    .sclk_i(sclk_i),
    .sdata_i(sdata_i),
    .load_i(load_i),
    .word_o(link_word),
    .toggle_o(link_toggle)
  );

  // ****************************************
  // Crossing to reference clock
  // ****************************************
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;
  logic tog_s1_next;
  logic tog_s2_next;
  logic tog_s3_next;
  logic word_strobe;

  always_comb begin
    tog_s1_next = tog_s1_reg;
    tog_s2_next = tog_s2_reg;
    tog_s3_next = tog_s3_reg;
    if (clk_en_i) begin
      tog_s1_next = link_toggle;
      tog_s2_next = tog_s1_reg;
      tog_s3_next = tog_s2_reg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      // Ready level idles high after a frame; no false edge after reset
      tog_s1_reg <= 1'b1;
      tog_s2_reg <= 1'b1;
      tog_s3_reg <= 1'b1;
    end else begin
      tog_s1_reg <= tog_s1_next;
      tog_s2_reg <= tog_s2_next;
      tog_s3_reg <= tog_s3_next;
    end
  end

  // Rising edge of the synced ready level; word is stable by then
  // A word completed while frozen is dropped
  assign word_strobe = clk_en_i && tog_s2_reg && !tog_s3_reg;

  // ****************************************
  // Register file
  // ****************************************
  logic [WORD_W-1:0] regs_reg [REG_COUNT];
  logic [WORD_W-1:0] regs_next [REG_COUNT];
  logic [7:0] written_reg;
  logic [7:0] written_next;
  logic init_done_reg;
  logic init_done_next;
  logic write_pulse_reg;
  logic write_pulse_next;
  logic [2:0] sel;

  assign sel = link_word[SEL_W-1:0];

  always_comb begin
    for (int i = 0; i < REG_COUNT; i++) begin
      regs_next[i] = regs_reg[i];
    end
    written_next = written_reg;
    init_done_next = init_done_reg;
    write_pulse_next = 1'b0;
    if (word_strobe) begin
      // Only the selected register changes; later rewrites always accepted
      regs_next[sel] = link_word;
      written_next[sel] = 1'b1;
      write_pulse_next = 1'b1;
      // First pass complete once register 0 lands after the rest
      if (sel == IDX_INTEGER_DIVIDE_CONTROL && (&written_reg[7:1])) begin
        init_done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_reg[i] <= RST_OTHER;
      end
      regs_reg[IDX_INTEGER_DIVIDE_CONTROL] <= RST_INTEGER_DIVIDE_CONTROL;
      regs_reg[IDX_MODULUS_DIVIDE] <= RST_MODULUS_DIVIDE;
      regs_reg[IDX_FRACTIONAL_DIVIDE] <= RST_FRACTIONAL_DIVIDE;
      written_reg <= 8'h00;
      init_done_reg <= 1'b0;
      write_pulse_reg <= 1'b0;
    end else if (clk_en_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_reg[i] <= regs_next[i];
      end
      written_reg <= written_next;
      init_done_reg <= init_done_next;
      write_pulse_reg <= write_pulse_next;
    end
  end

  // ****************************************
  // Decoded divider settings
  // ****************************************
  logic [WORD_W-1:0] r0;
  spr_div_mode_t mode;
  logic [6:0] int_ratio;
  logic [10:0] modulus;
  logic [10:0] frac_value;
  logic int_ok;
  logic frac_ok;
  logic [7:0] mult_next;
  logic [7:0] mult_reg;

  assign r0 = regs_reg[IDX_INTEGER_DIVIDE_CONTROL];
  assign mode = spr_div_mode_t'(r0[DIVIDE_MODE_BIT]);
  assign int_ratio = r0[INT_RATIO_LSB +: INT_RATIO_W];
  assign modulus = regs_reg[IDX_MODULUS_DIVIDE][MODULUS_LSB +: MODULUS_W];
  assign frac_value = regs_reg[IDX_FRACTIONAL_DIVIDE][FRAC_LSB +: FRAC_W];

  always_comb begin
    if (mode == SPR_MODE_INTEGER) begin
      int_ok = (int_ratio >= INT_MIN_INTEGER) && (int_ratio <= INT_MAX_INTEGER);
      frac_ok = 1'b1;
    end else begin
      int_ok = (int_ratio >= INT_MIN_FRACTIONAL) && (int_ratio <= INT_MAX_FRACTIONAL);
      frac_ok = (modulus >= MODULUS_MIN) && (modulus <= MODULUS_MAX)
        && (frac_value < modulus);
    end
    // Oscillator to detector-rate multiple in integer mode
    mult_next = (mode == SPR_MODE_INTEGER) ? {int_ratio, 1'b0} : 8'h00;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mult_reg <= 8'h00;
    end else if (clk_en_i) begin
      mult_reg <= mult_next;
    end
  end

  assign reg_file_o = regs_reg;
  assign oscillator_mult_o = mult_reg;
  assign write_pulse_o = write_pulse_reg;
  assign status_o.mode = mode;
  assign status_o.int_ratio = int_ratio;
  assign status_o.fractional_modulus = modulus;
  assign status_o.frac_value = frac_value;
  assign status_o.settings_valid = int_ok && frac_ok;
  assign status_o.written_mask = written_reg;
  assign status_o.init_done = init_done_reg;
endmodule // spr_config_regs

// ==== logic/spr_shifter.sv ====
// Link-side shift register, clocked by the host serial clock
module spr_shifter
  import spr_pkg::*;
#(
  parameter int unsigned WORD_W = 24
) (
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic load_i,
  output logic [WORD_W-1:0] word_o,
  output logic toggle_o
);
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] shift_next;
  logic [WORD_W-1:0] word_reg;
  logic [WORD_W-1:0] word_next;
  logic load_q_reg;
  logic load_q_next;

  always_comb begin
    shift_next = shift_reg;
    word_next = word_reg;
    load_q_next = load_i;
    if (!load_i) begin
      shift_next = {shift_reg[WORD_W-2:0], sdata_i};
    end
    if (load_i && !load_q_reg) begin
      word_next = shift_reg;
    end
  end

  always_ff @(posedge sclk_i) begin
    shift_reg <= shift_next;
    word_reg <= word_next;
    load_q_reg <= load_q_next;
  end

  assign word_o = word_reg;
  // Word-ready level: high from the latch edge until the next frame shifts
  // Known after one serial edge, so the link side needs no reset
  assign toggle_o = load_q_reg;
endmodule // spr_shifter
